// file: hw/pueseg_regs.sv
// power-down, update trigger and store-segment registers
// assumes the serial port delivers decoded byte strobes synchronous to clk_sys_i
// and flags each serial clock rising edge on sclk_rise_i
`timescale 1ns/1ps
`include "pueseg_cfg.svh"
module pueseg_regs
  import pueseg_pkg::*;
#(
  parameter int SEG_COUNT = `PUESEG_SEG_COUNT
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic sclk_rise_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire pueseg_addr_t reg_addr_i,
  input wire pueseg_byte_t reg_wdata_i,
  output pueseg_byte_t reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic walk_start_i,
  output logic walk_busy_o,
  output logic walk_done_o,
  output logic xfer_valid_o,
  output pueseg_addr_t xfer_addr_o,
  input wire logic xfer_ready_i,
  output logic update_pending_o,
  output logic update_apply_o,
  output logic pd_input_cleanup_loop_o,
  output logic pd_synthesis_loop_o,
  output logic pd_distribution_o
);
  localparam int IW = $clog2(SEG_COUNT);
  localparam int SEG_SPAN = `PUESEG_OFS_SEG_LAST - `PUESEG_OFS_SEG_FIRST + 1;

  // the default list and the address decode only serve the full span
  if (SEG_COUNT != SEG_SPAN) begin : g_bad_span
    $error("segment count does not match the segment address span");
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic hit_pd;
  logic hit_update;
  logic hit_seg;
  pueseg_addr_t seg_offset;
  logic [IW-1:0] host_idx;

  assign hit_pd = (reg_addr_i == `PUESEG_OFS_POWER_DOWN);
  assign hit_update = (reg_addr_i == `PUESEG_OFS_UPDATE);
  assign hit_seg = (reg_addr_i >= `PUESEG_OFS_SEG_FIRST) &&
                   (reg_addr_i <= `PUESEG_OFS_SEG_LAST);
  assign seg_offset = reg_addr_i - `PUESEG_OFS_SEG_FIRST;
  assign host_idx = seg_offset[IW-1:0];

  // ----------------------------------------------------------------
  // power-down, buffered and active copies
  // ----------------------------------------------------------------
  logic [`PUESEG_PD_WIDTH-1:0] pd_buf_r;
  logic [`PUESEG_PD_WIDTH-1:0] pd_act_r;
  logic update_pend_r;
  logic walk_apply;
  logic copy_now;

  // (RULE1) buffered power-down bits
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pd_buf_r <= `PUESEG_PD_RESET;
    end else if (reg_wr_i && hit_pd) begin
      pd_buf_r <= reg_wdata_i[`PUESEG_PD_WIDTH-1:0];
    end
  end

  // (RULE3) copy on serial edge
  // the apply opcode copies at once since the serial clock may be idle then
  assign copy_now = (update_pend_r && sclk_rise_i) || walk_apply;
  assign update_apply_o = copy_now;

  // (RULE9) one-edge active copy
  // any other active bank must load on update_apply_o in this same edge
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pd_act_r <= `PUESEG_PD_RESET;
    end else if (copy_now) begin
      pd_act_r <= pd_buf_r;
    end
  end

  assign pd_input_cleanup_loop_o = pd_act_r[`PUESEG_PD_CLEANUP_BIT];
  assign pd_synthesis_loop_o = pd_act_r[`PUESEG_PD_SYNTH_BIT];
  assign pd_distribution_o = pd_act_r[`PUESEG_PD_DIST_BIT];

  // ----------------------------------------------------------------
  // update trigger
  // ----------------------------------------------------------------
  logic update_set;
  assign update_set = reg_wr_i && hit_update && reg_wdata_i[`PUESEG_UPDATE_BIT];

  // (RULE2) request the copy
  // (RULE4) self-clearing, a new set wins
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      update_pend_r <= 1'b0;
    end else if (update_set) begin
      update_pend_r <= 1'b1;
    end else if (copy_now) begin
      update_pend_r <= 1'b0;
    end
  end

  assign update_pending_o = update_pend_r;

  // ----------------------------------------------------------------
  // segment table
  // ----------------------------------------------------------------
  localparam logic [8*`PUESEG_SEG_COUNT-1:0] SEG_INIT = `PUESEG_SEG_DEFAULT;
  pueseg_byte_t seg_r [SEG_COUNT];
  logic [IW-1:0] walk_idx;
  pueseg_byte_t walk_byte;

  // (RULE5) table storage
  // (RULE8) full-coverage reset list
  // host writes are dropped mid-walk so the list cannot change under the walker
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < SEG_COUNT; i++) begin
        seg_r[i] <= SEG_INIT[8*i +: 8];
      end
    end else if (reg_wr_i && hit_seg && !walk_busy_o) begin
      seg_r[host_idx] <= reg_wdata_i;
    end
  end

  // indices past the table read as the end opcode, never as unknowns
  always_comb begin
    walk_byte = `PUESEG_OP_END;
    if (int'(walk_idx) < SEG_COUNT) begin
      walk_byte = seg_r[walk_idx];
    end
  end

  // ----------------------------------------------------------------
  // store walker
  // ----------------------------------------------------------------
  pueseg_seg_walker #(
    .SEG_COUNT(SEG_COUNT)
  ) u_walker (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .start_i(walk_start_i),
    .seg_byte_i(walk_byte),
    .seg_index_o(walk_idx),
    .xfer_valid_o(xfer_valid_o),
    .xfer_addr_o(xfer_addr_o),
    .xfer_ready_i(xfer_ready_i),
    .apply_o(walk_apply),
    .busy_o(walk_busy_o),
    .done_o(walk_done_o)
  );

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  pueseg_byte_t rdata_nxt;

  // reserved and unmapped bits read as zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (hit_pd) begin
      rdata_nxt[`PUESEG_PD_WIDTH-1:0] = pd_buf_r;
    end else if (hit_update) begin
      rdata_nxt[`PUESEG_UPDATE_BIT] = update_pend_r;
    end else if (hit_seg) begin
      rdata_nxt = seg_r[host_idx];
    end
  end

  // read answer strobe, one cycle after the request
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
    end
  end

  // read data holds until the next read so a slow host can still take it
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_nxt;
    end
  end
endmodule : pueseg_regs

// file: hw/pueseg_cfg.svh
// constants for the power-down, update and store-segment register slice
// assumes a serial-port front end that turns host frames into byte strobes
// ----------------------------------------------------------------
// Overview of operation
// (RULE1) power-down bits: 2 cleanup loop, 1 synthesis loop, 0 distribution; reset 1
// (RULE2) writing 1 to update bit 0 copies buffered values into active registers
// (RULE3) the copy happens on the first serial clock rising edge after setting
// (RULE4) update bit clears itself after the copy; host never writes 0
// (RULE5) twenty-three byte segment registers hold range start addresses and byte counts
// (RULE6) store walker moves only the listed ranges, each with its own length
// (RULE7) table opcodes: apply-update triggers the copy, end-of-data stops the walk
// (RULE8) reset table covers every register range and ends with apply-update
// (RULE9) the copy updates all active registers on one clock edge
// ----------------------------------------------------------------
`ifndef PUESEG_CFG_SVH
`define PUESEG_CFG_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PUESEG_OFS_POWER_DOWN 12'h233
`define PUESEG_OFS_UPDATE 12'h234
`define PUESEG_OFS_SEG_FIRST 12'ha00
`define PUESEG_OFS_SEG_LAST 12'ha16

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define PUESEG_PD_CLEANUP_BIT 2
`define PUESEG_PD_SYNTH_BIT 1
`define PUESEG_PD_DIST_BIT 0
`define PUESEG_PD_WIDTH 3
`define PUESEG_PD_RESET 3'h7
`define PUESEG_UPDATE_BIT 0
`define PUESEG_SEG_COUNT 23

// ----------------------------------------------------------------
// segment entry encoding
// ----------------------------------------------------------------
// byte 0: bit 7 clear = range, bits 6:0 = byte count minus one
// bytes 1 and 2: start address high nibble then low byte
`define PUESEG_OP_APPLY 8'h80
`define PUESEG_OP_END 8'hff
`define PUESEG_OP_FLAG_BIT 7
// entry 0 in the low byte
`define PUESEG_SEG_DEFAULT 184'hffffffffffffff8000023480017f00017f80007f00007f

`endif

// file: hw/pueseg_pkg.sv
// shared types for the power-down, update and store-segment slice
// assumes pueseg_cfg.svh holds the numeric constants
package pueseg_pkg;
  typedef logic [7:0] pueseg_byte_t;
  typedef logic [11:0] pueseg_addr_t;
  typedef enum logic [2:0] {
    WALK_IDLE,
    WALK_HEAD,
    WALK_ADDR_HI,
    WALK_ADDR_LO,
    WALK_MOVE
  } pueseg_walk_e;
endpackage : pueseg_pkg

// file: hw/pueseg_seg_walker.sv
// segment table walker for the nonvolatile-store transfer engine
// assumes the table byte at seg_index_o is presented combinationally
`timescale 1ns/1ps
`include "pueseg_cfg.svh"
module pueseg_seg_walker
  import pueseg_pkg::*;
#(
  parameter int SEG_COUNT = `PUESEG_SEG_COUNT
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire pueseg_byte_t seg_byte_i,
  output logic [$clog2(SEG_COUNT)-1:0] seg_index_o,
  output logic xfer_valid_o,
  output pueseg_addr_t xfer_addr_o,
  input wire logic xfer_ready_i,
  output logic apply_o,
  output logic busy_o,
  output logic done_o
);
  localparam int IW = $clog2(SEG_COUNT);
  localparam logic [IW-1:0] LAST_IDX = IW'(SEG_COUNT - 1);

  // refuse tables too short for one range or too long for an 8-bit index
  if (SEG_COUNT < 3 || SEG_COUNT > 256) begin : g_bad_count
    $error("segment count out of range");
  end

  pueseg_walk_e state_r;
  logic [6:0] count_r;
  logic last_byte;

  assign last_byte = (seg_index_o == LAST_IDX);
  assign busy_o = (state_r != WALK_IDLE);
  assign xfer_valid_o = (state_r == WALK_MOVE);

  // ----------------------------------------------------------------
  // walk sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_r <= WALK_IDLE;
      seg_index_o <= '0;
      count_r <= '0;
      xfer_addr_o <= '0;
      apply_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      apply_o <= 1'b0;
      done_o <= 1'b0;
      unique case (state_r)
        WALK_IDLE: begin
          seg_index_o <= '0;
          if (start_i) begin
            state_r <= WALK_HEAD;
          end
        end
        WALK_HEAD: begin
          // (RULE7) opcodes in table
          if (seg_byte_i == `PUESEG_OP_APPLY) begin
            apply_o <= 1'b1;
            if (last_byte) begin
              state_r <= WALK_IDLE;
              done_o <= 1'b1;
            end else begin
              seg_index_o <= seg_index_o + 1'b1;
            end
          end else if (seg_byte_i[`PUESEG_OP_FLAG_BIT] || last_byte) begin
            // a range header in the final slot has no address; ends the list
            state_r <= WALK_IDLE;
            done_o <= 1'b1;
          end else begin
            count_r <= seg_byte_i[6:0];
            seg_index_o <= seg_index_o + 1'b1;
            state_r <= WALK_ADDR_HI;
          end
        end
        WALK_ADDR_HI: begin
          xfer_addr_o[11:8] <= seg_byte_i[3:0];
          if (last_byte) begin
            state_r <= WALK_IDLE;
            done_o <= 1'b1;
          end else begin
            seg_index_o <= seg_index_o + 1'b1;
            state_r <= WALK_ADDR_LO;
          end
        end
        WALK_ADDR_LO: begin
          xfer_addr_o[7:0] <= seg_byte_i;
          state_r <= WALK_MOVE;
        end
        WALK_MOVE: begin
          // (RULE6) only listed range moved
          if (xfer_ready_i) begin
            xfer_addr_o <= xfer_addr_o + 12'h001;
            count_r <= count_r - 7'h01;
            if (count_r == 7'h00) begin
              if (last_byte) begin
                state_r <= WALK_IDLE;
                done_o <= 1'b1;
              end else begin
                seg_index_o <= seg_index_o + 1'b1;
                state_r <= WALK_HEAD;
              end
            end
          end
        end
      endcase
    end
  end
endmodule : pueseg_seg_walker

// file: bench/pueseg_regs_asserts.sv
// checker for the power-down, update and segment register slice
// assumes binding to pueseg_regs, one clock domain
`timescale 1ns/1ps
`include "pueseg_cfg.svh"
module pueseg_regs_chk
  import pueseg_pkg::*;
#(
  parameter int SEG_COUNT = 23
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic sclk_rise_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire pueseg_addr_t reg_addr_i,
  input wire pueseg_byte_t reg_wdata_i,
  input wire pueseg_byte_t reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic walk_start_i,
  input wire logic walk_busy_o,
  input wire logic walk_done_o,
  input wire logic xfer_valid_o,
  input wire pueseg_addr_t xfer_addr_o,
  input wire logic xfer_ready_i,
  input wire logic update_pending_o,
  input wire logic update_apply_o,
  input wire logic pd_input_cleanup_loop_o,
  input wire logic pd_synthesis_loop_o,
  input wire logic pd_distribution_o
);
  // ----
  // properties
  // ----
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  wire [2:0] pd_w = {pd_input_cleanup_loop_o, pd_synthesis_loop_o, pd_distribution_o};
  // set wins over self-clear, so exclude it
  wire set_w = reg_wr_i && reg_addr_i == `PUESEG_OFS_UPDATE && reg_wdata_i[0];
  sequence s_accept;
    xfer_valid_o && xfer_ready_i;
  endsequence
  sequence s_copy;
    update_pending_o && sclk_rise_i;
  endsequence
  a_pd_reset: assert property ($rose(rst_n_i) |-> pd_w == 3'h7)
    else $error("power-down bits not set after reset");
  a_update_set: assert property (set_w |=> update_pending_o)
    else $error("update request not held");
  a_copy_edge: assert property (s_copy |-> update_apply_o)
    else $error("copy missed the serial clock edge");
  a_self_clear: assert property (s_copy ##0 !set_w |=> !update_pending_o)
    else $error("update bit did not clear");
  a_pd_stable: assert property (!update_apply_o |=> $stable(pd_w))
    else $error("active bits moved without a copy");
  a_read_resp: assert property (1'b1 |=> reg_rvalid_o == $past(reg_rd_i))
    else $error("read answer not one cycle later");
  a_walk_start: assert property (walk_start_i && !walk_busy_o |=> walk_busy_o)
    else $error("walk did not start");
  a_xfer_step: assert property (s_accept ##1 xfer_valid_o |-> xfer_addr_o == $past(xfer_addr_o) + 12'h1)
    else $error("transfer address did not step by one");
  a_xfer_hold: assert property (xfer_valid_o && !xfer_ready_i |=> xfer_valid_o && $stable(xfer_addr_o))
    else $error("offer dropped before accept");
  a_done_end: assert property (walk_done_o |-> !walk_busy_o ##1 !walk_done_o)
    else $error("done pulse malformed");
endmodule : pueseg_regs_chk

bind pueseg_regs pueseg_regs_chk #(.SEG_COUNT(SEG_COUNT)) pueseg_regs_chk_inst (.*);

// file: bench/pueseg_host_model.sv
// host model: byte register accesses, serial clock strobes, engine ready
// assumes the bench calls its tasks; drives 1 ns after the clock edge
`timescale 1ns/1ps
module pueseg_host_model
  import pueseg_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic slow_i,
  input wire pueseg_byte_t rdata_i,
  output logic wr_o,
  output logic rd_o,
  output pueseg_addr_t addr_o,
  output pueseg_byte_t wdata_o,
  output logic sclk_rise_o,
  output logic ready_o
);
  initial begin
    {wr_o, rd_o, sclk_rise_o, ready_o} = 4'h0;
    addr_o = 12'h0;
    wdata_o = 8'h0;
  end
  // engine stalls every other cycle when slow
  always @(posedge clk_sys_i) ready_o <= #1 (slow_i ? !ready_o : 1'b1);
  // host writes any byte value, zeros included
  // released lines show the inverse so stale values never pass
  task automatic wr(input pueseg_addr_t a, input pueseg_byte_t d);
    @(posedge clk_sys_i) #1;
    wr_o = 1'b1;
    addr_o = a;
    wdata_o = d;
    @(posedge clk_sys_i) #1;
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask : wr
  task automatic rd(input pueseg_addr_t a, output pueseg_byte_t d);
    @(posedge clk_sys_i) #1;
    rd_o = 1'b1;
    addr_o = a;
    @(posedge clk_sys_i) #1;
    rd_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
  endtask : rd
  task automatic sclk();
    @(posedge clk_sys_i) #1;
    sclk_rise_o = 1'b1;
    @(posedge clk_sys_i) #1;
    sclk_rise_o = 1'b0;
  endtask : sclk
endmodule : pueseg_host_model

// file: bench/testbench.sv
// self-checking bench for the power-down, update and segment slice
// assumes the host model drives the register port and engine ready
`timescale 1ns/1ps
`include "pueseg_cfg.svh"
module testbench
  import pueseg_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic walk_start_i = 1'b0;
  logic slow = 1'b0;
  logic reg_wr_i, reg_rd_i, sclk_rise_i, xfer_ready_i, reg_rvalid_o, walk_busy_o;
  logic walk_done_o, xfer_valid_o, update_pending_o, update_apply_o;
  logic pd_input_cleanup_loop_o, pd_synthesis_loop_o, pd_distribution_o;
  pueseg_addr_t reg_addr_i, xfer_addr_o, last_a;
  pueseg_byte_t reg_wdata_i, reg_rdata_o, rb;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  int acc_n, apply_n, done_n;
  logic [183:0] tbl = `PUESEG_SEG_DEFAULT;
  wire [2:0] pd = {pd_input_cleanup_loop_o, pd_synthesis_loop_o, pd_distribution_o};
  always #10 clk_sys_i = ~clk_sys_i;
  pueseg_regs #(.SEG_COUNT(23)) pueseg_regs_inst (.*);
  pueseg_host_model pueseg_host_model_inst (.clk_sys_i(clk_sys_i), .slow_i(slow),
    .rdata_i(reg_rdata_o), .wr_o(reg_wr_i), .rd_o(reg_rd_i), .addr_o(reg_addr_i),
    .wdata_o(reg_wdata_i), .sclk_rise_o(sclk_rise_i), .ready_o(xfer_ready_i));
  // ----
  // checking and closing
  // ----
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim();
    if (miscompares == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  // ceiling well above the slow default walk of about 1200 cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_sim();
    end
  end
  always @(posedge clk_sys_i) begin
    if (xfer_valid_o === 1'b1 && xfer_ready_i === 1'b1) begin
      acc_n++;
      last_a = xfer_addr_o;
    end
    if (update_apply_o === 1'b1) apply_n++;
    if (walk_done_o === 1'b1) done_n++;
  end
  task automatic walk(input logic s);
    slow = s;
    acc_n = 0;
    apply_n = 0;
    done_n = 0;
    @(posedge clk_sys_i) #1;
    walk_start_i = 1'b1;
    @(posedge clk_sys_i) #1;
    walk_start_i = 1'b0;
    for (int i = 0; i < 3000 && walk_busy_o !== 1'b0; i++) @(posedge clk_sys_i);
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk(walk_busy_o, 1'b0);
  endtask : walk
  // ----
  // scenarios
  // ----
  task automatic t_update();
    chk(pd, 3'h7);
    pueseg_host_model_inst.rd(`PUESEG_OFS_POWER_DOWN, rb);
    chk(rb, 8'h07);
    chk(reg_rvalid_o, 1'b1);
    pueseg_host_model_inst.rd(12'h235, rb);
    chk(rb, 8'h00);
    pueseg_host_model_inst.wr(`PUESEG_OFS_POWER_DOWN, 8'hfa);
    pueseg_host_model_inst.rd(`PUESEG_OFS_POWER_DOWN, rb);
    chk(rb, 8'h02);
    pueseg_host_model_inst.wr(`PUESEG_OFS_UPDATE, 8'h01);
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk({pd, update_pending_o}, 4'hf);
    pueseg_host_model_inst.sclk();
    chk({pd, update_pending_o}, 4'h4);
    pueseg_host_model_inst.rd(`PUESEG_OFS_UPDATE, rb);
    chk(rb, 8'h00);
  endtask : t_update
  task automatic t_table();
    for (int i = 0; i < 23; i++) begin
      pueseg_host_model_inst.rd(12'ha00 + 12'(i), rb);
      chk(rb, tbl[8*i +: 8]);
    end
  endtask : t_table
  // default list moves 0x000..0x234 then applies; slow engine stalls
  task automatic t_walk_default();
    pueseg_host_model_inst.wr(`PUESEG_OFS_POWER_DOWN, 8'h05);
    walk(1'b1);
    chk(acc_n[15:0], 16'h235);
    chk(last_a, 12'h234);
    chk({apply_n[3:0], done_n[3:0]}, 8'h11);
    chk(pd, 3'h5);
  endtask : t_walk_default
  task automatic t_walk_custom();
    for (int i = 0; i < 4; i++) begin
      pueseg_host_model_inst.wr(12'ha00 + 12'(i), 8'(32'h020233ff >> (24 - 8*i)));
    end
    pueseg_host_model_inst.rd(12'ha03, rb);
    chk(rb, 8'hff);
    pueseg_host_model_inst.wr(`PUESEG_OFS_POWER_DOWN, 8'h00);
    walk(1'b0);
    chk(acc_n[15:0], 16'h3);
    chk(last_a, 12'h235);
    chk({apply_n[3:0], done_n[3:0]}, 8'h01);
    chk(pd, 3'h5);
  endtask : t_walk_custom
  initial begin
    repeat (3) @(posedge clk_sys_i);
    #1;
    rst_n_i = 1'b1;
    t_update();
    t_table();
    t_walk_default();
    t_walk_custom();
    end_sim();
  end
endmodule : testbench
